// ==== ssram_pkg.sv ====
package ssram_pkg;
  localparam int ADDR_W = 15;
  localparam int DATA_W = 8;
  localparam int PAGE_W = 5;
  localparam logic [7:0] CMD_READ = 8'h03;
  localparam logic [7:0] CMD_WRITE = 8'h02;
  localparam logic [7:0] READ_MODE_REG_CMD = 8'h05;
  localparam logic [7:0] WRITE_MODE_REG_CMD = 8'h01;
  localparam logic [7:0] MODE_RESET = 8'h00;
  localparam int MODE_LSB = 6;
  localparam logic [1:0] MODE_BYTE = 2'h0;
  localparam logic [1:0] MODE_PAGE = 2'h2;
  localparam logic [1:0] MODE_BURST = 2'h1;
  typedef struct packed {
    logic sel_n;
    logic sck;
    logic sin;
    logic pause_n;
  } ssram_pins_s;
  typedef struct packed {
    logic rise;
    logic fall;
    logic active;
    logic sin;
    logic sel;
    logic hold;
  } ssram_evt_s;
endpackage : ssram_pkg

// ==== ssram_sync.sv ====
`timescale 1ns/1ns
module ssram_sync (
  input wire logic clk_sys,
  input wire logic nrst,
  input wire ssram_pkg::ssram_pins_s pins,
  output ssram_pkg::ssram_evt_s evt
);
  ssram_pkg::ssram_pins_s s1;
  ssram_pkg::ssram_pins_s s2;
  ssram_pkg::ssram_pins_s s3;
  ssram_pkg::ssram_evt_s next_evt;
  always_comb begin
    next_evt.active = !s2.sel_n && s2.pause_n;
    next_evt.rise = next_evt.active && s2.sck && !s3.sck;
    next_evt.fall = next_evt.active && !s2.sck && s3.sck;
    next_evt.sin = s2.sin;
    next_evt.sel = !s2.sel_n;
    next_evt.hold = !s2.pause_n;
  end
  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      s1 <= '{sel_n: 1'b1, sck: 1'b0, sin: 1'b0, pause_n: 1'b1};
      s2 <= '{sel_n: 1'b1, sck: 1'b0, sin: 1'b0, pause_n: 1'b1};
      s3 <= '{sel_n: 1'b1, sck: 1'b0, sin: 1'b0, pause_n: 1'b1};
      evt <= '0;
    end else begin
      s1 <= pins;
      s2 <= s1;
      s3 <= s2;
      evt <= next_evt;
    end
  end
endmodule : ssram_sync

// ==== ssram_mem.sv ====
`timescale 1ns/1ns
module ssram_mem #(
  parameter int AW = 15,
  parameter int DW = 8
) (
  input wire logic clk_sys,
  input wire logic we,
  input wire logic [AW-1:0] addr,
  input wire logic [DW-1:0] wdata,
  output logic [DW-1:0] rdata
);
  logic [DW-1:0] mem [2**AW];
  always_ff @(posedge clk_sys) begin
    if (we) begin
      mem[addr] <= wdata;
    end
  end
  always_comb begin
    rdata = mem[addr];
  end
endmodule : ssram_mem

// ==== ssram_spi_port.sv ====
`timescale 1ns/1ns
module ssram_spi_port #(
  parameter int AW = 15
) (
  input wire logic clk_sys,
  input wire logic nrst,
  input wire logic sel_n,
  input wire logic sck,
  input wire logic sin,
  input wire logic pause_n,
  output logic sout,
  output logic sout_oe
);
  typedef enum logic [2:0] {ST_IDLE, ST_CMD, ST_ADDR, ST_RDATA, ST_WDATA, ST_RMODE,
    ST_WMODE, ST_SINK} ssram_state_e;
  ssram_pkg::ssram_pins_s pins;
  ssram_pkg::ssram_evt_s evt;
  ssram_state_e state;
  ssram_state_e next_state;
  logic [7:0] cmd;
  logic [7:0] next_cmd;
  logic [7:0] shreg;
  logic [7:0] next_shreg;
  logic [7:0] txreg;
  logic [7:0] next_txreg;
  logic [3:0] bitcnt;
  logic [3:0] next_bitcnt;
  logic [AW-1:0] addr;
  logic [AW-1:0] next_addr;
  logic [7:0] mode;
  logic [7:0] next_mode;
  logic next_sout;
  logic next_sout_oe;
  logic mem_we;
  logic [7:0] mem_rdata;
  logic [7:0] rx_byte;
  logic [AW-1:0] addr_inc;
  logic [1:0] mode_sel;
  logic tx_arm;
  logic next_tx_arm;
  logic drv;
  logic next_drv;
  logic rd_phase;
  assign pins = '{sel_n: sel_n, sck: sck, sin: sin, pause_n: pause_n};
  ssram_sync u_sync (
    .clk_sys(clk_sys),
    .nrst(nrst),
    .pins(pins),
    .evt(evt)
  );
  ssram_mem #(.AW(AW), .DW(8)) u_mem (
    .clk_sys(clk_sys),
    .we(mem_we),
    .addr(addr),
    .wdata(rx_byte),
    .rdata(mem_rdata)
  );
  assign rx_byte = {shreg[6:0], evt.sin};
  assign mode_sel = mode[ssram_pkg::MODE_LSB +: 2];
  assign rd_phase = (state == ST_RDATA) || (state == ST_RMODE);
  // address step per mode
  always_comb begin
    unique case (mode_sel)
      ssram_pkg::MODE_PAGE: addr_inc = {addr[AW-1:ssram_pkg::PAGE_W],
        addr[ssram_pkg::PAGE_W-1:0] + 5'h01};
      ssram_pkg::MODE_BURST: addr_inc = addr + 15'h0001;
      default: addr_inc = addr;
    endcase
  end
  // transaction sequencing
  always_comb begin
    next_state = state;
    next_cmd = cmd;
    next_shreg = shreg;
    next_txreg = txreg;
    next_bitcnt = bitcnt;
    next_addr = addr;
    next_mode = mode;
    next_tx_arm = tx_arm;
    mem_we = 1'b0;
    if (!evt.sel) begin
      next_state = ST_IDLE;
    end
    if (state == ST_IDLE && evt.sel) begin
      next_state = ST_CMD;
      next_bitcnt = 4'h0;
      next_tx_arm = 1'b0;
    end
    if (evt.rise && state != ST_IDLE) begin
      next_shreg = rx_byte;
      next_bitcnt = bitcnt + 4'h1;
      unique case (state)
        ST_CMD: if (bitcnt == 4'h7) begin
          next_cmd = rx_byte;
          next_bitcnt = 4'h0;
          unique case (rx_byte)
            ssram_pkg::CMD_READ, ssram_pkg::CMD_WRITE: next_state = ST_ADDR;
            ssram_pkg::READ_MODE_REG_CMD: begin
              next_state = ST_RMODE;
              next_txreg = mode;
              next_tx_arm = 1'b1;
            end
            ssram_pkg::WRITE_MODE_REG_CMD: next_state = ST_WMODE;
            default: next_state = ST_SINK;
          endcase
        end
        ST_ADDR: begin
          next_addr = {addr[AW-2:0], evt.sin};
          if (bitcnt == 4'hF) begin
            next_bitcnt = 4'h0;
            next_state = (cmd == ssram_pkg::CMD_READ) ? ST_RDATA : ST_WDATA;
            next_tx_arm = (cmd == ssram_pkg::CMD_READ);
          end
        end
        ST_RDATA: if (bitcnt == 4'h7) begin
          next_bitcnt = 4'h0;
          next_addr = addr_inc;
          next_tx_arm = 1'b1;
        end
        ST_WDATA: if (bitcnt == 4'h7) begin
          mem_we = 1'b1;
          next_bitcnt = 4'h0;
          next_addr = addr_inc;
          if (mode_sel == ssram_pkg::MODE_BYTE) begin
            next_state = ST_SINK;
          end
        end
        ST_WMODE: if (bitcnt == 4'h7) begin
          next_mode = rx_byte;
          next_state = ST_SINK;
        end
        ST_RMODE: if (bitcnt == 4'h7) begin
          next_bitcnt = 4'h0;
          next_tx_arm = 1'b1;
        end
        default: next_bitcnt = 4'h0;
      endcase
    end
    if (tx_arm && state == ST_RDATA && !evt.rise) begin
      next_txreg = mem_rdata;
      next_tx_arm = 1'b0;
    end
    if (tx_arm && state == ST_RMODE && !evt.rise) begin
      next_txreg = mode;
      next_tx_arm = 1'b0;
    end
  end
  // serial output driver
  always_comb begin
    next_sout = sout;
    next_sout_oe = 1'b0;
    next_drv = drv;
    if (state == ST_IDLE) begin
      next_drv = 1'b0;
    end
    if (evt.active && rd_phase) begin
      next_sout_oe = drv || evt.fall;
    end
    if (evt.hold || !evt.sel) begin
      next_sout_oe = 1'b0;
    end
    if (evt.fall && rd_phase) begin
      next_sout = txreg[3'h7 - bitcnt[2:0]];
      next_drv = 1'b1;
    end
  end
  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      state <= ST_IDLE;
      cmd <= 8'h00;
      shreg <= 8'h00;
      txreg <= 8'h00;
      bitcnt <= 4'h0;
      addr <= '0;
      mode <= ssram_pkg::MODE_RESET;
      tx_arm <= 1'b0;
      sout <= 1'b0;
      sout_oe <= 1'b0;
      drv <= 1'b0;
    end else begin
      state <= next_state;
      cmd <= next_cmd;
      shreg <= next_shreg;
      txreg <= next_txreg;
      bitcnt <= next_bitcnt;
      addr <= next_addr;
      mode <= next_mode;
      tx_arm <= next_tx_arm;
      sout <= next_sout;
      sout_oe <= next_sout_oe;
      drv <= next_drv;
    end
  end
  // checks
  property p_idle_on_desel;
    @(posedge clk_sys) disable iff (!nrst) !evt.sel |=> state == ST_IDLE;
  endproperty
  a_idle_on_desel: assert property (p_idle_on_desel) else $error("busy while deselected");
  property p_oe_off_desel;
    @(posedge clk_sys) disable iff (!nrst) !evt.sel |=> !sout_oe;
  endproperty
  a_oe_off_desel: assert property (p_oe_off_desel) else $error("drive while deselected");
  property p_oe_off_pause;
    @(posedge clk_sys) disable iff (!nrst) evt.hold |=> !sout_oe;
  endproperty
  a_oe_off_pause: assert property (p_oe_off_pause) else $error("drive during pause");
  property p_pause_freeze;
    @(posedge clk_sys) disable iff (!nrst) (evt.hold && evt.sel)
      |=> $stable(bitcnt) && $stable(addr);
  endproperty
  a_pause_freeze: assert property (p_pause_freeze) else $error("state moved in pause");
  property p_cmd_capture;
    @(posedge clk_sys) disable iff (!nrst) (state == ST_CMD && evt.rise && bitcnt == 4'h7)
      |=> cmd == $past(rx_byte);
  endproperty
  a_cmd_capture: assert property (p_cmd_capture) else $error("command not captured");
  property p_read_dec;
    @(posedge clk_sys) disable iff (!nrst) (state == ST_CMD && evt.rise && bitcnt == 4'h7
      && rx_byte == ssram_pkg::CMD_READ) |=> state == ST_ADDR;
  endproperty
  a_read_dec: assert property (p_read_dec) else $error("read not decoded");
  property p_rmode_dec;
    @(posedge clk_sys) disable iff (!nrst) (state == ST_CMD && evt.rise && bitcnt == 4'h7
      && rx_byte == ssram_pkg::READ_MODE_REG_CMD) |=> state == ST_RMODE;
  endproperty
  a_rmode_dec: assert property (p_rmode_dec) else $error("mode read not decoded");
  property p_burst_wrap;
    @(posedge clk_sys) disable iff (!nrst) (state == ST_RDATA && evt.rise && bitcnt == 4'h7
      && mode_sel == ssram_pkg::MODE_BURST && addr == 15'h7FFF) |=> addr == 15'h0000;
  endproperty
  a_burst_wrap: assert property (p_burst_wrap) else $error("burst wrap wrong");
  property p_page_wrap;
    @(posedge clk_sys) disable iff (!nrst) (state == ST_WDATA && evt.rise && bitcnt == 4'h7
      && mode_sel == ssram_pkg::MODE_PAGE && addr[4:0] == 5'h1F)
      |=> addr == {$past(addr[14:5]), 5'h00};
  endproperty
  a_page_wrap: assert property (p_page_wrap) else $error("page wrap wrong");
  property p_wmode_dec;
    @(posedge clk_sys) disable iff (!nrst) (state == ST_CMD && evt.rise && bitcnt == 4'h7
      && rx_byte == ssram_pkg::WRITE_MODE_REG_CMD) |=> state == ST_WMODE;
  endproperty
  a_wmode_dec: assert property (p_wmode_dec) else $error("mode write not decoded");
  property p_write_dec;
    @(posedge clk_sys) disable iff (!nrst) (state == ST_CMD && evt.rise && bitcnt == 4'h7
      && rx_byte == ssram_pkg::CMD_WRITE) |=> state == ST_ADDR;
  endproperty
  a_write_dec: assert property (p_write_dec) else $error("write not decoded");
  property p_mode_store;
    @(posedge clk_sys) disable iff (!nrst) (state == ST_WMODE && evt.rise && bitcnt == 4'h7)
      |=> mode == $past(rx_byte);
  endproperty
  a_mode_store: assert property (p_mode_store) else $error("mode not stored");
  property p_byte_sink;
    @(posedge clk_sys) disable iff (!nrst) (state == ST_WDATA && evt.rise && bitcnt == 4'h7
      && mode_sel == ssram_pkg::MODE_BYTE) |=> state == ST_SINK;
  endproperty
  a_byte_sink: assert property (p_byte_sink) else $error("byte write not closed");
  property p_burst_wr_wrap;
    @(posedge clk_sys) disable iff (!nrst) (state == ST_WDATA && evt.rise && bitcnt == 4'h7
      && mode_sel == ssram_pkg::MODE_BURST && addr == 15'h7FFF) |=> addr == 15'h0000;
  endproperty
  a_burst_wr_wrap: assert property (p_burst_wr_wrap) else $error("wrong write wrap");
  property p_page_rd_wrap;
    @(posedge clk_sys) disable iff (!nrst) (state == ST_RDATA && evt.rise && bitcnt == 4'h7
      && mode_sel == ssram_pkg::MODE_PAGE && addr[4:0] == 5'h1F)
      |=> addr == {$past(addr[14:5]), 5'h00};
  endproperty
  a_page_rd_wrap: assert property (p_page_rd_wrap) else $error("read page wrap");
  property p_sout_change;
    @(posedge clk_sys) disable iff (!nrst) $changed(sout) |-> $past(evt.fall);
  endproperty
  a_sout_change: assert property (p_sout_change) else $error("output moved off fall");
  property p_addr_shift;
    @(posedge clk_sys) disable iff (!nrst) (state == ST_ADDR && evt.rise)
      |=> addr == {$past(addr[AW-2:0]), $past(evt.sin)};
  endproperty
  a_addr_shift: assert property (p_addr_shift) else $error("address not shifted");
  c_read: cover property (@(posedge clk_sys) state == ST_ADDR ##[1:400] state == ST_RDATA);
  c_write: cover property (@(posedge clk_sys) mem_we);
  c_mode_wr: cover property (@(posedge clk_sys) state == ST_WMODE ##[1:200] state == ST_SINK);
  c_pause: cover property (@(posedge clk_sys) evt.hold && state == ST_RDATA);
  c_rmode: cover property (@(posedge clk_sys) state == ST_RMODE && sout_oe);
endmodule : ssram_spi_port

// ==== ssram_host.sv ====
`timescale 1ns/1ns
module ssram_host (
  input wire logic clk_sys,
  input wire logic sout,
  input wire logic sout_oe,
  output logic sel_n,
  output logic sck,
  output logic sin,
  output logic pause_n,
  output logic rx_stb,
  output logic [7:0] rx
);
  localparam int HALF = 6;
  logic last;
  logic line;
  // released output floats: host sees inverse of last bit
  assign line = sout_oe ? sout : ~last;
  initial begin
    last = 1'b0;
    sel_n = 1'b1;
    sck = 1'b0;
    sin = 1'b0;
    pause_n = 1'b1;
    rx_stb = 1'b0;
    rx = 8'h00;
  end
  task automatic tick(input int n);
    repeat (n) @(posedge clk_sys);
  endtask : tick
  // select or deselect with clock parked low
  task automatic frame(input logic on);
    tick(HALF);
    sel_n <= ~on;
    tick(HALF);
  endtask : frame
  // one byte each way, optional pause after bit pb
  task automatic xfer(input logic [7:0] tx, input logic chk, input int pb);
    logic [7:0] r;
    for (int i = 7; i >= 0; i--) begin
      sin <= tx[i];
      tick(HALF);
      sck <= 1'b1;
      r[i] = line;
      last = r[i];
      tick(HALF);
      sck <= 1'b0;
      if (i == pb) begin
        tick(2);
        pause_n <= 1'b0;
        tick(3 * HALF);
        pause_n <= 1'b1;
      end
    end
    if (chk) begin
      rx <= r;
      rx_stb <= 1'b1;
      tick(1);
      rx_stb <= 1'b0;
    end
  endtask : xfer
endmodule : ssram_host

// ==== tb.sv ====
`timescale 1ns/1ns
module tb;
  logic clk_sys = 1'b0;
  logic nrst = 1'b0;
  logic sel_n, sck, sin, pause_n, sout, sout_oe, rx_stb;
  logic [7:0] rx;
  logic [7:0] exp_q[$];
  logic [7:0] idle = 8'h00;
  logic [7:0] d[3];
  logic [7:0] m;
  logic [15:0] a;
  int failures = 0;
  int total_checks = 0;
  int cycles = 0;
  int seed = 80079;
  always #4 clk_sys = ~clk_sys;
  ssram_spi_port i_dut (.clk_sys(clk_sys), .nrst(nrst), .sel_n(sel_n), .sck(sck), .sin(sin),
    .pause_n(pause_n), .sout(sout), .sout_oe(sout_oe));
  ssram_host i_host (.clk_sys(clk_sys), .sout(sout), .sout_oe(sout_oe), .sel_n(sel_n),
    .sck(sck), .sin(sin), .pause_n(pause_n), .rx_stb(rx_stb), .rx(rx));
  task automatic check(input logic [7:0] seen, input logic [7:0] exp);
    total_checks++;
    if (seen !== exp) begin
      failures++;
      $display("ERROR %0t: got %h expected %h", $time, seen, exp);
    end
  endtask : check
  task automatic end_of_test();
    if (failures == 0 && total_checks > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask : end_of_test
  task automatic cmd(input logic [7:0] c, input logic [15:0] ad);
    i_host.frame(1'b1);
    i_host.xfer(c, 1'b0, -1);
    i_host.xfer(ad[15:8], 1'b0, -1);
    i_host.xfer(ad[7:0], 1'b0, -1);
  endtask : cmd
  task automatic rd(input logic [7:0] e, input int pb);
    exp_q.push_back(e);
    i_host.xfer(8'h00, 1'b1, pb);
  endtask : rd
  task automatic mode_rd(input logic [7:0] e);
    i_host.frame(1'b1);
    i_host.xfer(ssram_pkg::READ_MODE_REG_CMD, 1'b0, -1);
    rd(e, -1);
    i_host.frame(1'b0);
  endtask : mode_rd
  function automatic logic [15:0] wrap(input int k, input logic [15:0] ad, input int i);
    if (k == 0) return {ad[15:5], 5'(ad[4:0] + i)};
    return {1'b0, 15'(ad[14:0] + i)};
  endfunction : wrap
  always @(posedge clk_sys) begin
    if (rx_stb === 1'b1) check(rx, exp_q.pop_front());
  end
  always @(posedge clk_sys) begin
    if (sel_n === 1'b0 && pause_n === 1'b1) idle <= 8'h00;
    else idle <= idle + 8'h01;
    if (idle == 8'h06) check({7'h00, sout_oe}, 8'h00);
  end
  always @(posedge clk_sys) begin
    cycles <= cycles + 1;
    if (cycles == 30000) begin
      failures++;
      end_of_test();
    end
  end
  initial begin
    repeat (8) @(posedge clk_sys);
    nrst <= 1'b1;
    repeat (4) @(posedge clk_sys);
    mode_rd(ssram_pkg::MODE_RESET);
    d[0] = 8'($random(seed));
    cmd(ssram_pkg::CMD_WRITE, 16'h8123);
    i_host.xfer(d[0], 1'b0, -1);
    i_host.xfer(~d[0], 1'b0, -1);
    i_host.frame(1'b0);
    cmd(8'hA5, 16'h0123);
    i_host.xfer(~d[0], 1'b0, -1);
    i_host.frame(1'b0);
    cmd(ssram_pkg::CMD_READ, 16'h0123);
    rd(d[0], -1);
    rd(d[0], -1);
    i_host.frame(1'b0);
    for (int k = 0; k < 2; k++) begin
      m = 8'h00;
      m[7:6] = (k == 0) ? ssram_pkg::MODE_PAGE : ssram_pkg::MODE_BURST;
      a = (k == 0) ? 16'h005E : 16'h7FFF;
      i_host.frame(1'b1);
      i_host.xfer(ssram_pkg::WRITE_MODE_REG_CMD, 1'b0, -1);
      i_host.xfer(m, 1'b0, -1);
      i_host.frame(1'b0);
      mode_rd(m);
      cmd(ssram_pkg::CMD_WRITE, a);
      for (int i = 0; i < 3; i++) begin
        d[i] = 8'($random(seed));
        i_host.xfer(d[i], 1'b0, -1);
      end
      i_host.frame(1'b0);
      cmd(ssram_pkg::CMD_READ, a);
      for (int i = 0; i < 3; i++) rd(d[i], (k == 1 && i == 1) ? 3 : -1);
      i_host.frame(1'b0);
      cmd(ssram_pkg::CMD_READ, wrap(k, a, 2));
      rd(d[2], -1);
      i_host.frame(1'b0);
    end
    repeat (20) @(posedge clk_sys);
    check(8'(exp_q.size()), 8'h00);
    end_of_test();
  end
endmodule : tb
